/* hw/lvc_level_ctrl.sv */
// lvc_level_ctrl: supply level control and converter resolution config
// assumes register port and load strobe come from logic on i_clk
//
// Notes on behaviour
// - 5-bit setpoint lives in bits 5:1 at 0x15, drives amplitude and limits.
// - square mode 00 targets about 1800 mV times 77/(77-1.25*setpoint).
// - sum mode 01 targets about 245 mV times the same factor.
// - constant current mode 10 drives (setpoint+1)/32 of full scale after the first configuration load, no loop.
// - monitor limits 0.72 V and 2.34 V scale with the same factor.
// - after configuration loads, square regulation starts from zero current.
// - resolution is bits 6:0 at 0x21 above bits 7:0 at 0x20.
// - mode field at 0x16 bits 1:0: square, sum, constant, test.
`timescale 1ns/1ps

module lvc_level_ctrl
  import lvc_pkg::*;
(
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  // register port
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  output      logic [7:0]           o_reg_rdata,
  output      logic                 o_reg_rvalid,
  // configuration loader
  input  wire logic                 i_cfg_loaded,
  // supply control
  output      logic [1:0]           o_level_control_mode,
  output      logic [1:0]           o_current_range,
  output      logic [2:0]           o_deadband_sel,
  output      logic                 o_loop_enable,
  output      logic                 o_loop_restart,
  output      logic [LVC_CUR_W-1:0] o_supply_current_units,
  output      logic [LVC_MV_W-1:0]  o_target_mv,
  output      logic [LVC_MV_W-1:0]  o_mon_min_mv,
  output      logic [LVC_MV_W-1:0]  o_mon_max_mv,
  // converter resolution
  output      logic [LVC_RES_W-1:0] o_resolution_select,
  output      logic [LVC_IPF_W-1:0] o_interpolation_factor
);

  // ---------------------------------------------------------------
  // register group
  // ---------------------------------------------------------------
  logic [7:0]           setpoint_reg, next_setpoint_reg;
  logic [7:0]           mode_reg, next_mode_reg;
  logic [7:0]           res_lo, next_res_lo;
  logic [7:0]           res_hi, next_res_hi;
  logic                 lo_pend, next_lo_pend;
  logic                 hi_pend, next_hi_pend;
  logic [LVC_RES_W-1:0] res_apply, next_res_apply;
  lvc_state_t           state, next_state;

  logic [LVC_SETPOINT_W-1:0] setpoint;
  logic [1:0]                mode_sel;
  logic [LVC_SCALE_W-1:0]    scale_q;

  assign setpoint = setpoint_reg[LVC_SETPOINT_LSB +: LVC_SETPOINT_W];
  assign mode_sel = mode_reg[LVC_MODE_LSB +: 2];

  always_comb begin
    next_setpoint_reg = setpoint_reg;
    next_mode_reg     = mode_reg;
    next_res_lo       = res_lo;
    next_res_hi       = res_hi;
    next_lo_pend      = lo_pend;
    next_hi_pend      = hi_pend;
    next_res_apply    = res_apply;
    next_state        = state;
    if ((lo_pend && hi_pend) || i_cfg_loaded) begin
      next_res_apply = {res_hi[6:0], res_lo};
      next_lo_pend   = 1'b0;
      next_hi_pend   = 1'b0;
    end
    if (i_cfg_loaded) begin
      next_state = LVC_RUN;
    end
    if (i_reg_wr) begin
      if (i_reg_addr == LVC_ADDR_SETPOINT) begin
        next_setpoint_reg = i_reg_wdata & 8'hfe;
      end else if (i_reg_addr == LVC_ADDR_MODE) begin
        next_mode_reg = i_reg_wdata & 8'h73;
      end else if (i_reg_addr == LVC_ADDR_RES_LO) begin
        next_res_lo  = i_reg_wdata;
        next_lo_pend = 1'b1;
      end else if (i_reg_addr == LVC_ADDR_RES_HI) begin
        next_res_hi  = i_reg_wdata;
        next_hi_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      setpoint_reg <= LVC_RST_SETPOINT;
      mode_reg     <= LVC_RST_MODE;
      res_lo       <= LVC_RST_RES_LO;
      res_hi       <= LVC_RST_RES_HI;
      lo_pend      <= 1'b0;
      hi_pend      <= 1'b0;
      res_apply    <= {LVC_RST_RES_HI[6:0], LVC_RST_RES_LO};
      state        <= LVC_IDLE;
    end else begin
      setpoint_reg <= next_setpoint_reg;
      mode_reg     <= next_mode_reg;
      res_lo       <= next_res_lo;
      res_hi       <= next_res_hi;
      lo_pend      <= next_lo_pend;
      hi_pend      <= next_hi_pend;
      res_apply    <= next_res_apply;
      state        <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // scale factor lookup
  // ---------------------------------------------------------------
  lvc_scale_rom u_rom (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_index  (setpoint),
    .o_scale  (scale_q)
  );

  // ---------------------------------------------------------------
  // output group
  // ---------------------------------------------------------------
  logic [7:0]            next_rdata;
  logic                  next_rvalid;
  logic                  next_loop_enable;
  logic                  next_restart;
  logic [LVC_CUR_W-1:0]  next_current;
  logic [LVC_MV_W-1:0]   next_target, next_min, next_max;
  logic [LVC_PROD_W-1:0] prod_target, prod_min, prod_max;
  logic [LVC_MV_W-1:0]   target_base;

  always_comb begin
    next_rvalid = i_reg_rd;
    if (i_reg_addr == LVC_ADDR_SETPOINT) begin
      next_rdata = setpoint_reg;
    end else if (i_reg_addr == LVC_ADDR_MODE) begin
      next_rdata = mode_reg;
    end else if (i_reg_addr == LVC_ADDR_RES_LO) begin
      next_rdata = res_lo;
    end else if (i_reg_addr == LVC_ADDR_RES_HI) begin
      next_rdata = res_hi;
    end else begin
      next_rdata = LVC_RDATA_NONE;
    end
    if (!i_reg_rd) begin
      next_rdata = LVC_RDATA_NONE;
    end
    next_restart     = i_cfg_loaded;
    next_loop_enable = (state == LVC_RUN) && !i_cfg_loaded &&
                       (mode_sel == LVC_MODE_SQUARE ||
                        mode_sel == LVC_MODE_SUM);
    next_current = '0;
    if (state == LVC_RUN && !i_cfg_loaded && mode_sel == LVC_MODE_CONST) begin
      next_current = LVC_CUR_W'({1'b0, setpoint}) + 6'h01;
    end
    target_base = '0;
    if (mode_sel == LVC_MODE_SQUARE) begin
      target_base = LVC_SQUARE_BASE_MV;
    end else if (mode_sel == LVC_MODE_SUM) begin
      target_base = LVC_SUM_BASE_MV;
    end
    prod_target = LVC_PROD_W'(target_base) * LVC_PROD_W'(scale_q);
    prod_min    = LVC_PROD_W'(LVC_MON_MIN_MV) * LVC_PROD_W'(scale_q);
    prod_max    = LVC_PROD_W'(LVC_MON_MAX_MV) * LVC_PROD_W'(scale_q);
    next_target = prod_target[LVC_FRAC +: LVC_MV_W];
    next_min    = prod_min[LVC_FRAC +: LVC_MV_W];
    next_max    = prod_max[LVC_FRAC +: LVC_MV_W];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata            <= LVC_RDATA_NONE;
      o_reg_rvalid           <= 1'b0;
      o_level_control_mode   <= LVC_RST_MODE[1:0];
      o_current_range        <= LVC_RST_SETPOINT[7:6];
      o_deadband_sel         <= LVC_RST_MODE[6:4];
      o_loop_enable          <= 1'b0;
      o_loop_restart         <= 1'b0;
      o_supply_current_units <= '0;
      o_target_mv            <= '0;
      o_mon_min_mv           <= '0;
      o_mon_max_mv           <= '0;
      o_resolution_select    <= {LVC_RST_RES_HI[6:0], LVC_RST_RES_LO};
      o_interpolation_factor <= '0;
    end else begin
      o_reg_rdata            <= next_rdata;
      o_reg_rvalid           <= next_rvalid;
      o_level_control_mode   <= mode_sel;
      o_current_range        <= setpoint_reg[LVC_RANGE_LSB +: 2];
      o_deadband_sel         <= mode_reg[LVC_DEADBAND_LSB +: 3];
      o_loop_enable          <= next_loop_enable;
      o_loop_restart         <= next_restart;
      o_supply_current_units <= next_current;
      o_target_mv            <= next_target;
      o_mon_min_mv           <= next_min;
      o_mon_max_mv           <= next_max;
      o_resolution_select    <= res_apply;
      o_interpolation_factor <= res_apply[LVC_RES_W-1:2] + 13'h0001;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_sp_write;
    i_reg_wr && i_reg_addr == LVC_ADDR_SETPOINT;
  endsequence
  sequence s_sp_read;
    !i_reg_wr && i_reg_rd && i_reg_addr == LVC_ADDR_SETPOINT;
  endsequence
  property p_setpoint_readback;
    s_sp_write ##1 s_sp_read |=>
      o_reg_rvalid && o_reg_rdata[5:1] == $past(i_reg_wdata[5:1], 2);
  endproperty
  a_setpoint_readback: assert property (p_setpoint_readback)
    else $error("setpoint readback mismatch");
  property p_square_target;
    $past(mode_sel) == LVC_MODE_SQUARE |->
      o_target_mv == LVC_MV_W'((32'(LVC_SQUARE_BASE_MV) *
                     32'($past(scale_q))) >> LVC_FRAC);
  endproperty
  a_square_target: assert property (p_square_target)
    else $error("square target wrong");

  property p_sum_target;
    $past(mode_sel) == LVC_MODE_SUM |->
      o_target_mv == LVC_MV_W'((32'(LVC_SUM_BASE_MV) *
                     32'($past(scale_q))) >> LVC_FRAC);
  endproperty
  a_sum_target: assert property (p_sum_target)
    else $error("sum target wrong");

  property p_const_current;
    state == LVC_RUN && !i_cfg_loaded && mode_sel == LVC_MODE_CONST |=>
      o_supply_current_units == 6'($past(setpoint)) + 6'h01 && !o_loop_enable;
  endproperty
  a_const_current: assert property (p_const_current)
    else $error("constant current level wrong");

  property p_mon_limits;
    ##1 1'b1 |-> o_mon_max_mv == LVC_MV_W'((32'(LVC_MON_MAX_MV) *
      32'($past(scale_q))) >> LVC_FRAC) && o_mon_min_mv == LVC_MV_W'((
      32'(LVC_MON_MIN_MV) * 32'($past(scale_q))) >> LVC_FRAC);
  endproperty
  a_mon_limits: assert property (p_mon_limits)
    else $error("monitor limits wrong");

  sequence s_first_load;
    state == LVC_IDLE && i_cfg_loaded;
  endsequence
  property p_start_zero;
    s_first_load |=> o_loop_restart && o_supply_current_units == '0 &&
      !o_loop_enable;
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("start not from zero current");

  property p_idle_quiet;
    state == LVC_IDLE |=> !o_loop_enable && o_supply_current_units == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("output active before load");

  property p_res_assembly;
    lo_pend && hi_pend |=> ##1
      o_resolution_select == {$past(res_hi[6:0], 2), $past(res_lo, 2)};
  endproperty
  a_res_assembly: assert property (p_res_assembly)
    else $error("resolution assembly wrong");

  property p_mode_decode;
    mode_sel == LVC_MODE_TEST |=> o_level_control_mode == LVC_MODE_TEST &&
      !o_loop_enable && o_supply_current_units == '0;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("test mode not inert");

  property p_no_mixed_res;
    $changed(res_apply) |-> $past(lo_pend && hi_pend) || $past(i_cfg_loaded);
  endproperty
  a_no_mixed_res: assert property (p_no_mixed_res)
    else $error("resolution applied from one byte");

endmodule // lvc_level_ctrl

/* hw/lvc_pkg.sv */
// lvc_pkg: constants for the level control and resolution configuration
// assumes a byte-wide register port and one 125 MHz clock
package lvc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] LVC_ADDR_SETPOINT = 8'h15;
  localparam logic [7:0] LVC_ADDR_MODE     = 8'h16;
  localparam logic [7:0] LVC_ADDR_RES_LO   = 8'h20;
  localparam logic [7:0] LVC_ADDR_RES_HI   = 8'h21;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int LVC_SETPOINT_LSB = 1;
  localparam int LVC_SETPOINT_W   = 5;
  localparam int LVC_RANGE_LSB    = 6;
  localparam int LVC_MODE_LSB     = 0;
  localparam int LVC_DEADBAND_LSB = 4;
  localparam int LVC_RES_W        = 15;
  localparam int LVC_IPF_W        = 13;
  localparam int LVC_MV_W         = 14;
  localparam int LVC_CUR_W        = 6;
  localparam int LVC_SCALE_W      = 12;
  localparam int LVC_PROD_W       = 26;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LVC_RST_SETPOINT = 8'h00;
  localparam logic [7:0] LVC_RST_MODE     = 8'h00;
  localparam logic [7:0] LVC_RST_RES_LO   = 8'h03;
  localparam logic [7:0] LVC_RST_RES_HI   = 8'h00;
  localparam logic [7:0] LVC_RDATA_NONE   = 8'h00;

  // ---------------------------------------------------------------
  // control mode codes
  // ---------------------------------------------------------------
  localparam logic [1:0] LVC_MODE_SQUARE = 2'h0;
  localparam logic [1:0] LVC_MODE_SUM    = 2'h1;
  localparam logic [1:0] LVC_MODE_CONST  = 2'h2;
  localparam logic [1:0] LVC_MODE_TEST   = 2'h3;

  // ---------------------------------------------------------------
  // setpoint scaling: factor = 77 / (77 - 1.25 * code)
  // held as 308 / (308 - 5 * code) in fixed point
  // ---------------------------------------------------------------
  localparam int LVC_SCALE_NUM  = 308;
  localparam int LVC_SCALE_STEP = 5;
  localparam int LVC_FRAC       = 10;

  localparam logic [LVC_MV_W-1:0] LVC_SQUARE_BASE_MV = 14'h0708; // 1800
  localparam logic [LVC_MV_W-1:0] LVC_SUM_BASE_MV    = 14'h00f5; // 245
  localparam logic [LVC_MV_W-1:0] LVC_MON_MIN_MV     = 14'h02d0; // 720
  localparam logic [LVC_MV_W-1:0] LVC_MON_MAX_MV     = 14'h0924; // 2340

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    LVC_IDLE,
    LVC_RUN
  } lvc_state_t;

endpackage

/* hw/lvc_scale_rom.sv */
// lvc_scale_rom: setpoint to fixed-point scale factor table
// assumes same clock as the register logic; read data is registered
`timescale 1ns/1ps

module lvc_scale_rom
  import lvc_pkg::*;
#(
  parameter int IDX_W  = LVC_SETPOINT_W,
  parameter int DATA_W = LVC_SCALE_W
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // lookup
  input  wire logic [IDX_W-1:0]  i_index,
  output      logic [DATA_W-1:0] o_scale
);

  // ---------------------------------------------------------------
  // table built at elaboration
  // ---------------------------------------------------------------
  function automatic int scale_of(input int k);
    return (LVC_SCALE_NUM << LVC_FRAC) / (LVC_SCALE_NUM - LVC_SCALE_STEP * k);
  endfunction

  logic [DATA_W-1:0] table_q [2**IDX_W];
  logic [DATA_W-1:0] next_scale;

  for (genvar g = 0; g < 2**IDX_W; g++) begin : g_entry
    assign table_q[g] = DATA_W'(scale_of(g));
  end

  always_comb begin
    next_scale = table_q[i_index];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_scale <= '0;
    end else begin
      o_scale <= next_scale;
    end
  end

endmodule // lvc_scale_rom

/* sim/lvc_cfg_src.sv */
// lvc_cfg_src: configuration loader model, signals a finished load
// assumes the bench clock; latency picked per request
`timescale 1ns/1ps

module lvc_cfg_src (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // request from bench
  input  wire logic       i_go,
  input  wire logic [3:0] i_lat,
  // load done pulse
  output      logic       o_loaded
);
  logic [4:0] cnt;

  // countdown, then one-cycle done pulse
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt      <= 5'h00;
      o_loaded <= 1'b0;
    end else begin
      o_loaded <= (cnt == 5'h01);
      if (i_go) begin
        cnt <= {1'b0, i_lat} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // lvc_cfg_src

/* sim/level_control_and_resolution_cfg_tb.sv */
// level_control_and_resolution_cfg_tb: self-checking bench with model
// assumes lvc_pkg and lvc_level_ctrl compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module level_control_and_resolution_cfg_tb;
  import lvc_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdat;
  logic go = 1'b0, cfg_loaded, rvalid, en, rst_p;
  logic [3:0] lat = 4'h0;
  logic [1:0] mode_o, range_o;
  logic [2:0] db_o;
  logic [LVC_CUR_W-1:0] cur_o;
  logic [LVC_MV_W-1:0] tgt_o, min_o, max_o;
  logic [LVC_RES_W-1:0] res_o;
  logic [LVC_IPF_W-1:0] ipf_o;
  int n_errors = 0, n_checks = 0, cycles = 0, seed = 32'h45b554f1;
  int sp, mode, running, prev, v;
  logic [7:0] b8;
  int res_tab [8] = '{'h0003, 'h0007, 'h0013, 'h0063, 'h01f3, 'h07cf,
                      'h0f9f, 'h0fff};

  always #4 i_clk = ~i_clk;

  lvc_level_ctrl dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(rdat), .o_reg_rvalid(rvalid), .i_cfg_loaded(cfg_loaded),
    .o_level_control_mode(mode_o), .o_current_range(range_o),
    .o_deadband_sel(db_o), .o_loop_enable(en), .o_loop_restart(rst_p),
    .o_supply_current_units(cur_o), .o_target_mv(tgt_o),
    .o_mon_min_mv(min_o), .o_mon_max_mv(max_o),
    .o_resolution_select(res_o), .o_interpolation_factor(ipf_o));

  lvc_cfg_src u_src (.i_clk(i_clk), .i_resetn(i_resetn), .i_go(go),
    .i_lat(lat), .o_loaded(cfg_loaded));

  // ---------------------------------------------------------------
  // model and tasks
  // ---------------------------------------------------------------
  function automatic int mv(int base, int s);
    return (base * ((308 * 1024) / (308 - 5 * s))) >>> 10;
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdat, e)
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e);
    wr(a, d);
    reg_rd <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdat, e)
  endtask

  task automatic chk_out();
    int t;
    t = (mode == 0) ? mv(1800, sp) : (mode == 1) ? mv(245, sp) : 0;
    `CHK(tgt_o, LVC_MV_W'(t))
    `CHK(min_o, LVC_MV_W'(mv(720, sp)))
    `CHK(max_o, LVC_MV_W'(mv(2340, sp)))
    `CHK(en, 1'(running != 0 && mode < 2))
    `CHK(cur_o, LVC_CUR_W'((running != 0 && mode == 2) ? sp + 1 : 0))
  endtask

  task automatic load();
    @(posedge i_clk);
    go <= 1'b1;
    lat <= 4'($random(seed));
    @(posedge i_clk);
    go <= 1'b0;
    for (int k = 0; k < 40 && cfg_loaded !== 1'b1; k++) wait_n(1);
    wait_n(1);
    `CHK(rst_p, 1'b1)
    `CHK(cur_o, 6'h00)
    `CHK(en, 1'b0)
    running = 1;
    wait_n(1);
    `CHK(rst_p, 1'b0)
    chk_out();
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sp = 0; mode = 0; running = 0; prev = 'h0003;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd_chk(LVC_ADDR_SETPOINT, 8'h00);
    rd_chk(LVC_ADDR_MODE, 8'h00);
    rd_chk(LVC_ADDR_RES_LO, 8'h03);
    rd_chk(LVC_ADDR_RES_HI, 8'h00);
    rd_chk(8'h40, 8'h00);
    `CHK(res_o, 15'h0003)
    chk_out();
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      sp = (i == 0) ? 31 : (i == 1) ? 0 : ($random(seed) & 31);
      b8 = {2'($random(seed)), 5'(sp), 1'b1};
      wr_rd(LVC_ADDR_SETPOINT, b8, {b8[7:1], 1'b0});
      wait_n(3);
      chk_out();
      `CHK(range_o, b8[7:6])
      rd_chk(LVC_ADDR_SETPOINT, {b8[7:1], 1'b0});
    end
    $display("test setpoint done");
    sp = 19;
    wr(LVC_ADDR_SETPOINT, 8'h26);
    // constant current used for calibration, all four mode codes written and loaded in turn
    for (int m = 0; m < 4; m++) begin
      b8 = {1'b1, 3'($random(seed)), 2'b11, 2'(m)};
      wr(LVC_ADDR_MODE, b8);
      mode = m;
      load();
      `CHK(mode_o, 2'(m))
      `CHK(db_o, b8[6:4])
      rd_chk(LVC_ADDR_MODE, {1'b0, b8[6:4], 2'b00, 2'(m)});
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++) begin
      v = res_tab[i];
      b8 = {i[0], 7'(v >> 8)};
      if (i[0]) wr(LVC_ADDR_RES_HI, b8);
      else wr(LVC_ADDR_RES_LO, 8'(v));
      wait_n(4);
      `CHK(res_o, LVC_RES_W'(prev))
      if (i[0]) wr(LVC_ADDR_RES_LO, 8'(v));
      else wr(LVC_ADDR_RES_HI, b8);
      wait_n(4);
      `CHK(res_o, LVC_RES_W'(v))
      `CHK(ipf_o, LVC_IPF_W'((v + 1) / 4))
      rd_chk(LVC_ADDR_RES_HI, b8);
      rd_chk(LVC_ADDR_RES_LO, 8'(v));
      prev = v;
    end
    $display("test resolution done");
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    sp = 0; mode = 0; running = 0;
    wait_n(3);
    `CHK(res_o, 15'h0003)
    `CHK(mode_o, 2'b00)
    chk_out();
    load();
    $display("test second reset done");
    give_verdict();
  end
endmodule // level_control_and_resolution_cfg_tb
